// ===== logic/urx_receiver.sv
`timescale 1ns/1ns
`default_nettype none
`include "urx_regs.svh"
module urx_receiver
    import urx_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sampleTick,
    input wire logic rxdPin,
    output logic rxPinOwned,
    output logic rxIrq
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // The pointers wrap naturally only for a power-of-two depth.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("DEPTH must be a power of two of at least 2.");
    end

    // Two-of-three vote.
    function automatic logic maj3(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // Data bits per character from the size field; unused codes mean eight.
    function automatic logic [3:0] dataBits(input logic [2:0] sz);
        case (sz)
            3'h0: return 4'h5;
            3'h1: return 4'h6;
            3'h2: return 4'h7;
            3'h7: return 4'h9;
            default: return 4'h8;
        endcase
    endfunction

    logic pinS1_q, pinS2_q, pinS3_q, rxLine_q, rxLine_d;
    logic u2x_q, rxcie_q, rxen_q, pen_q, podd_q, stopSel_q;
    logic [2:0] size_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [4:0] awAddr_q;
    logic [7:0] wByte_q;
    logic wStrb0_q;
    logic rxPinOwned_q, rxIrq_q;
    urx_state_t state_q;
    logic [4:0] cnt_q;
    logic [3:0] bitIdx_q;
    logic v1_q, v2_q, par_q, lost_q;
    logic [8:0] shift_q;
    logic [8:0] bufData_q [DEPTH];
    logic [2:0] bufFlags_q [DEPTH];
    logic [PW-1:0] wrPtr_q, rdPtr_q;
    logic [CW-1:0] count_q, count_d;
    logic pendValid_q;
    logic [8:0] pendData_q;
    logic [2:0] pendFlags_q;

    // Receive line filter: a change counts once the last two stages agree.
    assign rxLine_d = (pinS2_q == pinS3_q) ? pinS3_q : rxLine_q;

    // Three flip-flops on the pin; they reset to the idle level, so no false start
    // edge follows reset.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pinS1_q <= 1'b1;
            pinS2_q <= 1'b1;
            pinS3_q <= 1'b1;
            rxLine_q <= 1'b1;
        end else begin
            pinS1_q <= rxdPin;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            rxLine_q <= rxLine_d;
        end
    end

    // Sample position decode for the current speed.
    wire logic [4:0] spb = u2x_q ? `URX_SPB_DBL : `URX_SPB_NORM;
    wire logic [4:0] sf = u2x_q ? `URX_SF_DBL : `URX_SF_NORM;
    wire logic [4:0] sf1 = sf + 5'h01;
    wire logic [4:0] sf2 = sf + 5'h02;
    wire logic [4:0] cntNext = (cnt_q == spb) ? 5'h01 : cnt_q + 5'h01;
    wire logic tick = sampleTick & rxen_q;
    wire logic isDec = tick && (cnt_q == sf2);
    wire logic vote = maj3(v1_q, v2_q, rxLine_q);
    wire logic [3:0] nData = dataBits(size_q);
    wire logic [3:0] nStop = nData + {3'h0, pen_q};
    wire logic isData = bitIdx_q < nData;
    wire logic isStop = bitIdx_q == nStop;

    // Frame events.
    wire logic startSeen = tick && state_q == RX_IDLE && !rxLine_q;
    wire logic startOk = isDec && state_q == RX_START && !vote;
    wire logic frameDone = isDec && state_q == RX_BITS && isStop;
    wire logic full = count_q == DEPTH_C;
    wire logic overrun = startOk && pendValid_q && full;

    // Parity mismatch, only counted while checking is enabled.
    // The parity settings are taken when the stop bit is decided.
    wire logic parErr = pen_q & ((^shift_q) ^ podd_q ^ par_q);
    wire logic [2:0] newFlags = {~vote, lost_q, parErr};

    // Recovery sequencer; a cleared enable abandons the frame at once.
    // The sample counter restarts at one on the first low sample of a start bit.
    always_ff @(posedge sys_clk) begin
        if (!rstn || !rxen_q) begin
            state_q <= RX_IDLE;
            cnt_q <= 5'h00;
        end else if (startSeen) begin
            state_q <= RX_START;
            cnt_q <= 5'h01;
        end else if (tick) begin
            cnt_q <= cntNext;
            if (state_q == RX_START && isDec) begin
                state_q <= vote ? RX_IDLE : RX_BITS;
            end else if (frameDone) begin
                state_q <= RX_IDLE;
            end
        end
    end

    // Centre samples and bit assembly.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            v1_q <= 1'b1;
            v2_q <= 1'b1;
            bitIdx_q <= 4'h0;
            shift_q <= 9'h000;
            par_q <= 1'b0;
        end else begin
            if (tick && cnt_q == sf) begin
                v1_q <= rxLine_q;
            end
            if (tick && cnt_q == sf1) begin
                v2_q <= rxLine_q;
            end
            if (startOk) begin
                bitIdx_q <= 4'h0;
                shift_q <= 9'h000;
            end else if (isDec && state_q == RX_BITS) begin
                bitIdx_q <= bitIdx_q + 4'h1;
                if (isData) begin
                    shift_q[bitIdx_q] <= vote;
                end else if (!isStop) begin
                    par_q <= vote;
                end
            end
        end
    end

    // Buffer movement: a waiting character goes first, then a new one.
    wire logic space = count_q < DEPTH_C;
    wire logic pushPend = pendValid_q & space;
    wire logic pushFrame = frameDone & space & ~pendValid_q;
    wire logic push = pushPend | pushFrame;
    wire logic [8:0] pushData = pushPend ? pendData_q : shift_q;
    wire logic [2:0] pushFlags = pushPend ? pendFlags_q : newFlags;
    wire logic rdHs = s_axi_arvalid & arready_q;
    wire logic rdIsData = {s_axi_araddr[4:2], 2'b00} == `URX_OFS_DATA;
    wire logic pop = rdHs & rdIsData & (count_q != '0);

    // Next fill count; a disabled receiver holds it at zero.
    always_comb begin
        count_d = count_q;
        if (!rxen_q) begin
            count_d = '0;
        end else begin
            count_d = count_q + CW'(push) - CW'(pop);
        end
    end

    // Buffer storage; flags travel with their character.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            bufData_q[wrPtr_q] <= pushData;
            bufFlags_q[wrPtr_q] <= pushFlags;
        end
    end

    // Pointers and fill count; a cleared enable empties the buffer at once.
    always_ff @(posedge sys_clk) begin
        if (!rstn || !rxen_q) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + PW'(push);
            rdPtr_q <= rdPtr_q + PW'(pop);
            count_q <= count_d;
        end
    end

    // Character left in the shift stage and the lost-frame marker.
    // An overrun drops the waiting character and marks the next stored one.
    // A waiting character always enters the buffer first to keep the order.
    always_ff @(posedge sys_clk) begin
        if (!rstn || !rxen_q) begin
            pendValid_q <= 1'b0;
            pendData_q <= 9'h000;
            pendFlags_q <= 3'h0;
            lost_q <= 1'b0;
        end else begin
            if (overrun) begin
                pendValid_q <= 1'b0;
                lost_q <= 1'b1;
            end else if (frameDone && !pushFrame) begin
                pendValid_q <= 1'b1;
                pendData_q <= shift_q;
                pendFlags_q <= newFlags;
                lost_q <= 1'b0;
            end else if (pushPend) begin
                pendValid_q <= 1'b0;
            end
            if (pushFrame) begin
                lost_q <= 1'b0;
            end
        end
    end

    // Head of the buffer as software sees it.
    wire logic rxc = count_q != '0;
    wire logic [2:0] headFlags = rxc ? bufFlags_q[rdPtr_q] : 3'h0;
    wire logic [8:0] headData = rxc ? bufData_q[rdPtr_q] : 9'h000;
    wire logic [7:0] stByte = (8'(rxc) << `URX_ST_RXC)
        | (8'(headFlags[2]) << `URX_ST_FE)
        | (8'(headFlags[1]) << `URX_ST_DOR)
        | (8'(headFlags[0]) << `URX_ST_UPE)
        | (8'(u2x_q) << `URX_ST_U2X);
    wire logic [7:0] cbByte = (8'(rxcie_q) << `URX_CB_RXCIE)
        | (8'(rxen_q) << `URX_CB_RXEN)
        | (8'(headData[8]) << `URX_CB_RXB8);
    wire logic [7:0] ccByte = (8'(pen_q) << `URX_CC_PEN)
        | (8'(podd_q) << `URX_CC_PODD)
        | (8'(stopSel_q) << `URX_CC_STOP)
        | {5'h00, size_q};
    // Read address decode; anything past the data word is refused.
    wire logic [4:0] rdOfs = {s_axi_araddr[4:2], 2'b00};
    wire logic rdMapped = rdOfs <= `URX_OFS_DATA;
    wire logic [7:0] rdByte = (rdOfs == `URX_OFS_STATUS) ? stByte
        : (rdOfs == `URX_OFS_CTRLB) ? cbByte
        : (rdOfs == `URX_OFS_CTRLC) ? ccByte
        : (rdOfs == `URX_OFS_DATA) ? headData[7:0] : 8'h00;

    // Read channel: one answer per address, taken in one cycle.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `URX_RESP_OK;
        end else if (rdHs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rdByte};
            rresp_q <= rdMapped ? `URX_RESP_OK : `URX_RESP_ERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Write channel: address and data are held until both have come.
    wire logic doWrite = !awready_q && !wready_q && !bvalid_q;
    wire logic wrLow = doWrite && wStrb0_q;
    wire logic wrCb = wrLow && awAddr_q == `URX_OFS_CTRLB;
    wire logic wrCc = wrLow && awAddr_q == `URX_OFS_CTRLC;
    wire logic wrSt = wrLow && awAddr_q == `URX_OFS_STATUS;
    wire logic wrMapped = awAddr_q <= `URX_OFS_DATA;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `URX_RESP_OK;
            awAddr_q <= 5'h00;
            wByte_q <= 8'h00;
            wStrb0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awAddr_q <= {s_axi_awaddr[4:2], 2'b00};
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wByte_q <= s_axi_wdata[7:0];
                wStrb0_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awready_q <= 1'b1;
                wready_q <= 1'b1;
                bvalid_q <= 1'b1;
                bresp_q <= wrMapped ? `URX_RESP_OK : `URX_RESP_ERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Control bits; status writes touch only the speed bit.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            u2x_q <= 1'b0;
            rxcie_q <= 1'b0;
            rxen_q <= 1'b0;
            pen_q <= 1'b0;
            podd_q <= 1'b0;
            stopSel_q <= 1'b0;
            size_q <= `URX_SIZE_RST;
        end else begin
            if (wrSt) begin
                u2x_q <= wByte_q[`URX_ST_U2X];
            end
            if (wrCb) begin
                rxcie_q <= wByte_q[`URX_CB_RXCIE];
                rxen_q <= wByte_q[`URX_CB_RXEN];
            end
            if (wrCc) begin
                pen_q <= wByte_q[`URX_CC_PEN];
                podd_q <= wByte_q[`URX_CC_PODD];
                stopSel_q <= wByte_q[`URX_CC_STOP];
                size_q <= wByte_q[`URX_CC_SIZE_HI:0];
            end
        end
    end

    // Pin ownership and the completion request; error flags take no part.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rxPinOwned_q <= 1'b0;
            rxIrq_q <= 1'b0;
        end else begin
            rxPinOwned_q <= rxen_q;
            rxIrq_q <= rxcie_q && count_d != '0;
        end
    end

    // Every output comes straight from a register.
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign rxPinOwned = rxPinOwned_q;
    assign rxIrq = rxIrq_q;

endmodule
`default_nettype wire

// ===== pkg/urx_regs.svh
`ifndef URX_REGS_SVH
`define URX_REGS_SVH

// Byte offsets of the registers on the bus.
`define URX_OFS_STATUS 5'h00
`define URX_OFS_CTRLB 5'h04
`define URX_OFS_CTRLC 5'h08
`define URX_OFS_DATA 5'h0C

// Status register bit positions.
`define URX_ST_RXC 7
`define URX_ST_FE 4
`define URX_ST_DOR 3
`define URX_ST_UPE 2
`define URX_ST_U2X 1

// Control register B bit positions.
`define URX_CB_RXCIE 7
`define URX_CB_RXEN 4
`define URX_CB_RXB8 1

// Control register C bit positions and size field.
`define URX_CC_PEN 5
`define URX_CC_PODD 4
`define URX_CC_STOP 3
`define URX_CC_SIZE_HI 2

// Reset value of the character size field (eight bits).
`define URX_SIZE_RST 3'h3

// Samples per bit and first voting sample, normal and double speed.
`define URX_SPB_NORM 5'h10
`define URX_SPB_DBL 5'h08
`define URX_SF_NORM 5'h08
`define URX_SF_DBL 5'h04

// Bus responses.
`define URX_RESP_OK 2'h0
`define URX_RESP_ERR 2'h2
`endif

// ===== pkg/urx_pkg.sv
`default_nettype none
package urx_pkg;

    // Receive sequencer states.
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_BITS
    } urx_state_t;

endpackage
`default_nettype wire

// ===== testbench/urx_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "urx_regs.svh"
// Watches the register bus answers and the receive request outputs.
module urx_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxPinOwned,
    input wire logic rxIrq
);
    logic [2:0] evAge_q;
    logic [2:0] evAge_d;
    logic evNow;
    // Age since the last write answer or data read, the only causes of a falling output.
    assign evNow = s_axi_bvalid || (s_axi_arvalid && s_axi_arready && s_axi_araddr == `URX_OFS_DATA);
    assign evAge_d = evNow ? 3'h0 : evAge_q + {2'h0, evAge_q != 3'h7};
    // Saturating age counter.
    always_ff @(posedge sys_clk) begin
        evAge_q <= rstn ? evAge_d : 3'h7;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_irq_needs_pin: assert property (rxIrq |-> rxPinOwned || $past(rxPinOwned))
        else $error("receive request while the pin is released");
    a_irq_holds: assert property ($fell(rxIrq) |-> evAge_q < 3'h4)
        else $error("receive request dropped without a data read");
    a_pin_by_write: assert property ($fell(rxPinOwned) |-> evAge_q < 3'h5)
        else $error("receive pin released without a control write");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4]
        |=> s_axi_rresp == `URX_RESP_ERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles after request");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer withdrawn early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer withdrawn early");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    c_irq: cover property ($rose(rxIrq));
    c_release: cover property ($fell(rxPinOwned));
    c_unmapped: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4]);
endmodule
`default_nettype wire

// ===== testbench/urx_serial_tx.sv
`timescale 1ns/1ns
`default_nettype none
// Remote transmitter driving the receive line, one bit per group of sample ticks.
module urx_serial_tx (
    input wire logic sys_clk,
    input wire logic sampleTick,
    output var logic rxdPin
);
    // The line idles high between frames.
    initial rxdPin = 1'b1;
    // Waits for a number of sample ticks.
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk iff sampleTick);
    endtask
    // Sends start, eight data bits with the lowest first, an optional parity bit, then stop.
    task automatic send(input logic [7:0] d, input logic par, input logic pBit, input logic stop,
        input int spb);
        logic [9:0] f;
        f = {pBit, d, 1'b0};
        for (int i = 0; i < (par ? 10 : 9); i++) begin
            rxdPin <= f[i];
            ticks(spb);
        end
        // The stop level lasts past the vote samples only, so a low stop is not a new start.
        rxdPin <= stop;
        ticks(spb / 2 + 2);
        rxdPin <= 1'b1;
        ticks(spb);
    endtask
endmodule
`default_nettype wire

// ===== testbench/uart_receive_buffer_status_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "urx_regs.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errorCnt++; \
    $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module uart_receive_buffer_status_tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sampleTick = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rxdPin, rxPinOwned, rxIrq;
    logic [1:0] s_axi_bresp, s_axi_rresp, tickCnt = 2'h0;
    int errorCnt = 0, totalChecks = 0;
    urx_receiver i_dut (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sampleTick(sampleTick), .rxdPin(rxdPin),
        .rxPinOwned(rxPinOwned), .rxIrq(rxIrq));
    urx_serial_tx i_tx (.sys_clk(sys_clk), .sampleTick(sampleTick), .rxdPin(rxdPin));
    // System clock.
    initial forever #5 sys_clk = ~sys_clk;
    // Sample tick every fourth clock, standing in for the baud generator.
    always @(posedge sys_clk) begin
        tickCnt <= tickCnt + 2'h1;
        sampleTick <= (tickCnt == 2'h3);
    end
    // Prints the verdict and stops.
    task automatic endSim();
        if (errorCnt == 0 && totalChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic hang();
        errorCnt++;
        endSim();
    endtask
    // Bus write: address and data offered together, each released when taken.
    // The answer is made to stand one cycle before it is accepted.
    task automatic axiWr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        if (n == 50) hang();
    endtask
    // Bus read; the answer is made to stand one cycle before it is accepted.
    task automatic axiRd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 50) hang();
    endtask
    task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axiRd(a, d, r);
        `CHK({r, d}, {`URX_RESP_OK, 24'h0, e})
    endtask
    // Reset values and refused accesses.
    task automatic scMap();
        logic [31:0] d;
        logic [1:0] r;
        rdChk(`URX_OFS_CTRLC, {5'h00, `URX_SIZE_RST});
        rdChk(`URX_OFS_CTRLB, 8'h00);
        axiRd(5'h14, d, r);
        `CHK({r, d}, {`URX_RESP_ERR, 32'h0})
        axiWr(5'h18, 8'hFF, `URX_RESP_ERR);
        axiWr(`URX_OFS_DATA, 8'h12, `URX_RESP_OK);
        rdChk(`URX_OFS_STATUS, 8'h00);
    endtask
    // One clean character.
    task automatic scBasic();
        axiWr(`URX_OFS_CTRLB, 8'h10, `URX_RESP_OK);
        repeat (3) @(posedge sys_clk);
        `CHK(rxPinOwned, 1'b1)
        i_tx.send(8'hA5, 1'b0, 1'b0, 1'b1, 16);
        rdChk(`URX_OFS_STATUS, 8'h80);
        rdChk(`URX_OFS_DATA, 8'hA5);
        rdChk(`URX_OFS_STATUS, 8'h00);
    endtask
    // Flags stored per character, then overrun with a full buffer and a waiting character.
    task automatic scErrors();
        axiWr(`URX_OFS_CTRLC, 8'h2B, `URX_RESP_OK);
        i_tx.send(8'h11, 1'b1, ^8'h11, 1'b0, 16);
        i_tx.send(8'h22, 1'b1, ~^8'h22, 1'b1, 16);
        i_tx.send(8'h33, 1'b1, ^8'h33, 1'b1, 16);
        i_tx.send(8'h44, 1'b1, ^8'h44, 1'b1, 16);
        `CHK(rxIrq, 1'b0)
        axiWr(`URX_OFS_STATUS, 8'h00, `URX_RESP_OK);
        rdChk(`URX_OFS_STATUS, 8'h90);
        rdChk(`URX_OFS_DATA, 8'h11);
        rdChk(`URX_OFS_STATUS, 8'h84);
        rdChk(`URX_OFS_DATA, 8'h22);
        rdChk(`URX_OFS_STATUS, 8'h88);
        rdChk(`URX_OFS_DATA, 8'h44);
        rdChk(`URX_OFS_STATUS, 8'h00);
        i_tx.send(8'h55, 1'b1, ^8'h55, 1'b1, 16);
        rdChk(`URX_OFS_STATUS, 8'h80);
        rdChk(`URX_OFS_DATA, 8'h55);
    endtask
    // Parity off, even and odd; an even parity bit is sent only while parity is on.
    task automatic scParity();
        logic [7:0] cfg [3] = '{8'h13, 8'h23, 8'h33};
        logic [7:0] st [3] = '{8'h80, 8'h80, 8'h84};
        for (int i = 0; i < 3; i++) begin
            axiWr(`URX_OFS_CTRLC, cfg[i], `URX_RESP_OK);
            i_tx.send(8'h6B, cfg[i][5], ^8'h6B, 1'b1, 16);
            rdChk(`URX_OFS_STATUS, st[i]);
            rdChk(`URX_OFS_DATA, 8'h6B);
        end
        // Nine data bits: the extra bit shows in control register B before the data read.
        axiWr(`URX_OFS_CTRLC, 8'h07, `URX_RESP_OK);
        i_tx.send(8'hC3, 1'b1, 1'b1, 1'b1, 16);
        rdChk(`URX_OFS_CTRLB, 8'h12);
        rdChk(`URX_OFS_DATA, 8'hC3);
        axiWr(`URX_OFS_CTRLC, {5'h00, `URX_SIZE_RST}, `URX_RESP_OK);
    endtask
    // Double speed with the request enabled and a bad stop.
    task automatic scIrq();
        axiWr(`URX_OFS_STATUS, 8'h02, `URX_RESP_OK);
        axiWr(`URX_OFS_CTRLB, 8'h90, `URX_RESP_OK);
        i_tx.send(8'h5A, 1'b0, 1'b0, 1'b0, 8);
        rdChk(`URX_OFS_STATUS, 8'h92);
        `CHK(rxIrq, 1'b1)
        rdChk(`URX_OFS_DATA, 8'h5A);
        repeat (3) @(posedge sys_clk);
        `CHK(rxIrq, 1'b0)
        axiWr(`URX_OFS_STATUS, 8'h00, `URX_RESP_OK);
    endtask
    // Disable with one character held and another frame under way.
    task automatic scDisable();
        i_tx.send(8'h66, 1'b0, 1'b0, 1'b1, 16);
        `CHK(rxIrq, 1'b1)
        fork
            i_tx.send(8'h77, 1'b0, 1'b0, 1'b1, 16);
            begin
                repeat (120) @(posedge sys_clk);
                axiWr(`URX_OFS_CTRLB, 8'h80, `URX_RESP_OK);
                repeat (3) @(posedge sys_clk);
                `CHK(rxIrq, 1'b0)
                `CHK(rxPinOwned, 1'b0)
            end
        join
        axiWr(`URX_OFS_CTRLB, 8'h90, `URX_RESP_OK);
        repeat (3) @(posedge sys_clk);
        `CHK(rxPinOwned, 1'b1)
        rdChk(`URX_OFS_STATUS, 8'h00);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        scMap();
        scBasic();
        scErrors();
        scParity();
        scIrq();
        scDisable();
        endSim();
    end
endmodule
bind urx_receiver urx_chk i_chk (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rxPinOwned(rxPinOwned), .rxIrq(rxIrq));
`default_nettype wire
